//--- include/sup_pkg.sv
// constants and state types for the mode, wake and watchdog supervisor
// assumes a single 25 MHz system clock; figures converted to cycles here, except T_POST_MS and T_SLST_MS
package sup_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	// ---------------------------------------------------------------
	// times as printed
	// ---------------------------------------------------------------
	localparam int unsigned T_POST_MS = 70;
	localparam int unsigned T_STNO_MS = 10;
	localparam int unsigned T_SLST_MS = 50;
	localparam int unsigned T_DOM_WAKE_US = 5;
	localparam int unsigned T_REC_WAKE_US = 5;
	localparam int unsigned T_RWAKE_US = 24;
	localparam int unsigned T_LWFILT_MIN_NS = 750;
	localparam int unsigned T_LWAKE_US = 32;
	localparam int unsigned T_DOMTO_US = 1000;
	localparam int unsigned T_RES_MS = 8;
	localparam int unsigned T_WDINIT_MS = 300;
	// ---------------------------------------------------------------
	// cycle counts (least times round up)
	// ---------------------------------------------------------------
	localparam int unsigned CYC_US = CLK_HZ / 1000000;
	localparam int unsigned CYC_MS = CLK_HZ / 1000;
	localparam int unsigned DOM_WAKE_CYC = T_DOM_WAKE_US * CYC_US;
	localparam int unsigned REC_WAKE_CYC = T_REC_WAKE_US * CYC_US;
	localparam int unsigned RWAKE_CYC = T_RWAKE_US * CYC_US;
	localparam int unsigned LWFILT_CYC = (T_LWFILT_MIN_NS * CYC_US + 999) / 1000;
	localparam int unsigned LWAKE_CYC = T_LWAKE_US * CYC_US;
	localparam int unsigned DOMTO_CYC = T_DOMTO_US * CYC_US;
	localparam int unsigned RES_CYC = T_RES_MS * CYC_MS;
	localparam int unsigned WDINIT_CYC = T_WDINIT_MS * CYC_MS;
	localparam int unsigned STNO_CYC = T_STNO_MS * CYC_MS;
	// window bounds as eighths of the period: 3/8 .. 5/8
	localparam int unsigned WIN_LO_8TH = 3;
	localparam int unsigned WIN_HI_8TH = 5;
	localparam int unsigned WIN_PERIOD_DEF = 250000;
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_NORMAL = 2'h1;
	localparam logic [1:0] CMD_SLEEP = 2'h2;
	localparam logic [1:0] CMD_STANDBY = 2'h3;
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_STARTWD = 3'b001,
		ST_STANDBY = 3'b010,
		ST_NORMAL = 3'b011,
		ST_SLEEP = 3'b100
	} mode_t;
endpackage

//--- rtl/dom_timeout.sv
// dominant-level timeout: flags when its input stays low past a limit
// assumes input synchronous to sys_clk_i; dominant is low
`timescale 1ns/1ps
module dom_timeout
	import sup_pkg::*;
#(
	parameter int unsigned LIMIT = DOMTO_CYC
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire logic dom_n_i,
	output logic fail_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic fail;
	} dto_t;
	dto_t q_r, q_nxt;
	always_comb begin
		q_nxt = q_r;
		if (dom_n_i) begin
			// failing condition cleared: release the transmitter
			q_nxt.cnt = 16'h0000;
			q_nxt.fail = 1'b0;
		end else if (q_r.cnt >= 16'(LIMIT)) begin
			q_nxt.fail = 1'b1;
		end else begin
			q_nxt.cnt = q_r.cnt + 16'h0001;
		end
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q_r <= '0;
		end else if (en_i) begin
			q_r <= q_nxt;
		end
	end
	assign fail_o = q_r.fail;
	property p_dto_clear;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(en_i && dom_n_i) |=> !fail_o;
	endproperty
	a_dto_clear: assert property (p_dto_clear) else $error("timeout not cleared");
endmodule // dom_timeout

//--- rtl/mode_wake_watchdog_supervisor.sv
// mode sequencer with wake detection, dominant timeouts and watchdogs
// assumes all inputs synchronous to sys_clk_i; dominant levels are low
`timescale 1ns/1ps
// Overview of operation
// - after power-up standby is reached within 70 ms, reset delay included, start-up wait excluded.
// - a normal-mode command from standby completes within 10 ms.
// - a wake in sleep leads to standby within 50 ms, reset delay included.
// - a remote-wake dominant phase counts only if at least 5 us long.
// - a remote-wake recessive phase counts only if at least 5 us long.
// - remote wake is signalled 24 us after the valid pattern is seen.
// - the wake pin passes a glitch filter of 0.75 to 5 us before the local wake flag.
// - local wake is declared 32 us after a qualifying wake pin edge.
// - in normal mode, transmit data dominant past about 1000 us flags a local failure.
// - in normal mode, bus dominant past about 1000 us flags a clamping failure.
// - after reset release the host gets 300 ms to give its first trigger.
// - window watchdog triggers are accepted only between 3/8 and 5/8 of the period.
// - a timely start-up trigger moves the device into standby.
// - a missed start-up trigger asserts reset and restarts the reset delay.
module mode_wake_watchdog_supervisor
	import sup_pkg::*;
#(
	parameter int unsigned RES_CYCLES = RES_CYC,
	parameter int unsigned WDINIT_CYCLES = WDINIT_CYC,
	parameter int unsigned WIN_PERIOD = WIN_PERIOD_DEF,
	parameter int unsigned DOMTO_CYCLES = DOMTO_CYC
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	input wire logic [1:0] mode_cmd_i,
	input wire logic wd_trig_i,
	input wire logic txd_i,
	input wire logic bus_rx_i,
	input wire logic wake_pin_i,
	output logic host_rst_n_o,
	output logic [2:0] mode_o,
	output logic tx_drive_o,
	output logic txd_fail_o,
	output logic bus_fail_o,
	output logic remote_wake_o,
	output logic local_wake_o,
	output logic wd_fail_o
);
	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	typedef struct packed {
		mode_t mode;
		logic [23:0] tmr;
		logic [23:0] win_cnt;
		logic [8:0] ph;
		logic [1:0] pat;
		logic bus_q;
		logic [9:0] rw_dly;
		logic rw_pend;
		logic rwake;
		logic [4:0] flt;
		logic wk_st;
		logic [9:0] lw_dly;
		logic lw_pend;
		logic lwake;
		logic wdf;
		logic rst_n;
	} sup_t;
	sup_t s_r, s_nxt;
	logic txd_fail, bus_fail, in_normal;
	assign in_normal = (s_r.mode == ST_NORMAL);
	// -------------------------------------------------------------
	// dominant timeouts
	// -------------------------------------------------------------
	dom_timeout #(.LIMIT(DOMTO_CYCLES)) u_txd_to (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.en_i(clk_en_i),
		.dom_n_i(txd_i | ~in_normal),
		.fail_o(txd_fail)
	);
	dom_timeout #(.LIMIT(DOMTO_CYCLES)) u_bus_to (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.en_i(clk_en_i),
		.dom_n_i(bus_rx_i | ~in_normal),
		.fail_o(bus_fail)
	);
	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	logic wake_any;
	always_comb begin
		s_nxt = s_r;
		s_nxt.rwake = 1'b0;
		s_nxt.lwake = 1'b0;
		s_nxt.wdf = 1'b0;
		wake_any = 1'b0;
		// remote wake: dom >=5us, rec >=5us, dom >=5us
		s_nxt.bus_q = bus_rx_i;
		if (s_r.mode == ST_SLEEP || s_r.mode == ST_STANDBY) begin
			if (bus_rx_i != s_r.bus_q) begin
				s_nxt.ph = 9'h000;
				// the phase count restarts at zero on the edge, so a full phase reads one less
				if (!s_r.bus_q && s_r.ph >= 9'(DOM_WAKE_CYC - 1)) begin
					s_nxt.pat = (s_r.pat == 2'h0) ? 2'h1 : 2'h3;
				end else if (s_r.bus_q && s_r.ph >= 9'(REC_WAKE_CYC - 1)) begin
					s_nxt.pat = (s_r.pat == 2'h1) ? 2'h2 : s_r.pat;
				end else begin
					s_nxt.pat = 2'h0;
				end
			end else if (s_r.ph != 9'h1FF) begin
				s_nxt.ph = s_r.ph + 9'h001;
			end
			if (s_r.pat == 2'h3 && !s_r.rw_pend) begin
				s_nxt.rw_pend = 1'b1;
				s_nxt.rw_dly = 10'h000;
				s_nxt.pat = 2'h0;
			end
			// local wake: filter then fixed detection delay
			if (wake_pin_i != s_r.wk_st) begin
				if (s_r.flt >= 5'(LWFILT_CYC)) begin
					s_nxt.wk_st = wake_pin_i;
					s_nxt.flt = 5'h00;
					// a second edge while pending must not push the first wake out
					if (!s_r.lw_pend) begin
						s_nxt.lw_pend = 1'b1;
						s_nxt.lw_dly = 10'h000;
					end
				end else begin
					s_nxt.flt = s_r.flt + 5'h01;
				end
			end else begin
				s_nxt.flt = 5'h00;
			end
		end else begin
			s_nxt.pat = 2'h0;
			s_nxt.ph = 9'h000;
			s_nxt.wk_st = wake_pin_i;
			s_nxt.flt = 5'h00;
		end
		if (s_r.rw_pend) begin
			if (s_r.rw_dly >= 10'(RWAKE_CYC - 1)) begin
				s_nxt.rw_pend = 1'b0;
				s_nxt.rwake = 1'b1;
			end else begin
				s_nxt.rw_dly = s_r.rw_dly + 10'h001;
			end
		end
		if (s_r.lw_pend) begin
			if (s_r.lw_dly >= 10'(LWAKE_CYC - LWFILT_CYC - 1)) begin
				s_nxt.lw_pend = 1'b0;
				s_nxt.lwake = 1'b1;
			end else begin
				s_nxt.lw_dly = s_r.lw_dly + 10'h001;
			end
		end
		wake_any = s_r.rwake | s_r.lwake;
		// mode sequencing
		s_nxt.tmr = s_r.tmr + 24'h000001;
		case (s_r.mode)
			ST_RESET: begin
				s_nxt.rst_n = 1'b0;
				if (s_r.tmr >= 24'(RES_CYCLES - 1)) begin
					s_nxt.mode = ST_STARTWD;
					s_nxt.tmr = 24'h000000;
					s_nxt.rst_n = 1'b1;
				end
			end
			ST_STARTWD: begin
				if (wd_trig_i) begin
					s_nxt.mode = ST_STANDBY;
					s_nxt.win_cnt = 24'h000000;
				end else if (s_r.tmr >= 24'(WDINIT_CYCLES - 1)) begin
					s_nxt.mode = ST_RESET;
					s_nxt.tmr = 24'h000000;
					s_nxt.rst_n = 1'b0;
					s_nxt.wdf = 1'b1;
				end
			end
			ST_STANDBY, ST_NORMAL: begin
				// window watchdog runs in both awake modes
				s_nxt.win_cnt = s_r.win_cnt + 24'h000001;
				if (wd_trig_i) begin
					if (s_r.win_cnt >= 24'(WIN_PERIOD * WIN_LO_8TH / 8) &&
						s_r.win_cnt < 24'(WIN_PERIOD * WIN_HI_8TH / 8)) begin
						s_nxt.win_cnt = 24'h000000;
					end else begin
						s_nxt.wdf = 1'b1;
					end
				end else if (s_r.win_cnt >= 24'(WIN_PERIOD * WIN_HI_8TH / 8)) begin
					s_nxt.wdf = 1'b1;
				end
				if (s_nxt.wdf) begin
					s_nxt.mode = ST_RESET;
					s_nxt.tmr = 24'h000000;
					s_nxt.rst_n = 1'b0;
				end else if (s_r.mode == ST_STANDBY && mode_cmd_i == CMD_NORMAL) begin
					s_nxt.mode = ST_NORMAL;
				end else if (mode_cmd_i == CMD_SLEEP) begin
					s_nxt.mode = ST_SLEEP;
				end else if (s_r.mode == ST_NORMAL && mode_cmd_i == CMD_STANDBY) begin
					s_nxt.mode = ST_STANDBY;
				end
			end
			ST_SLEEP: begin
				// host supply off in sleep, so it is held in reset
				s_nxt.rst_n = 1'b0;
				if (wake_any) begin
					s_nxt.mode = ST_RESET;
					s_nxt.tmr = 24'h000000;
				end
			end
			default: begin
				s_nxt.mode = ST_RESET;
				s_nxt.tmr = 24'h000000;
			end
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= '{mode: ST_RESET, bus_q: 1'b1, default: '0};
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end
	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign host_rst_n_o = s_r.rst_n;
	assign mode_o = s_r.mode;
	// transmitter forced recessive while either timeout stands
	assign tx_drive_o = in_normal & ~txd_fail & ~bus_fail & ~txd_i;
	assign txd_fail_o = txd_fail;
	assign bus_fail_o = bus_fail;
	assign remote_wake_o = s_r.rwake;
	assign local_wake_o = s_r.lwake;
	assign wd_fail_o = s_r.wdf;
	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	sequence s_cmd_normal;
		clk_en_i && s_r.mode == ST_STANDBY && mode_cmd_i == CMD_NORMAL && !s_nxt.wdf;
	endsequence
	property p_stno;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		s_cmd_normal |=> s_r.mode == ST_NORMAL;
	endproperty
	a_stno: assert property (p_stno) else $error("normal mode not entered");
	property p_sw_ok;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && s_r.mode == ST_STARTWD && wd_trig_i) |=> s_r.mode == ST_STANDBY;
	endproperty
	a_sw_ok: assert property (p_sw_ok) else $error("standby not entered");
	property p_sw_miss;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && s_r.mode == ST_STARTWD && !wd_trig_i && s_r.tmr >= 24'(WDINIT_CYCLES - 1))
		|=> !host_rst_n_o && s_r.mode == ST_RESET && s_r.tmr == 24'h000000;
	endproperty
	a_sw_miss: assert property (p_sw_miss) else $error("missed start trigger no reset");
	property p_win_early;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && (s_r.mode == ST_STANDBY || in_normal) && wd_trig_i
			&& s_r.win_cnt < 24'(WIN_PERIOD * WIN_LO_8TH / 8))
		|=> wd_fail_o && !host_rst_n_o;
	endproperty
	a_win_early: assert property (p_win_early) else $error("early trigger accepted");
	property p_win_ok;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && in_normal && wd_trig_i && s_r.win_cnt >= 24'(WIN_PERIOD * WIN_LO_8TH / 8)
			&& s_r.win_cnt < 24'(WIN_PERIOD * WIN_HI_8TH / 8)) |=> !wd_fail_o;
	endproperty
	a_win_ok: assert property (p_win_ok) else $error("window trigger refused");
	property p_rst_len;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(host_rst_n_o) |-> $past(s_r.mode) == ST_RESET;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset released early");
	property p_sleep_wake;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(clk_en_i && s_r.mode == ST_SLEEP && (remote_wake_o || local_wake_o))
		|=> s_r.mode == ST_RESET;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("wake ignored in sleep");
	property p_tx_forced;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(txd_fail_o || bus_fail_o) |-> !tx_drive_o;
	endproperty
	a_tx_forced: assert property (p_tx_forced) else $error("tx driven during fault");
endmodule // mode_wake_watchdog_supervisor

//--- tb/host_model.sv
// host microcontroller model: watchdog triggers and transmit data
// assumes the supervisor's clock and the mode encoding of sup_pkg
`timescale 1ns/1ps
module host_model
	import sup_pkg::*;
(
	input wire logic clk_i,
	input wire logic host_rst_n_i,
	input wire logic [2:0] mode_i,
	input wire logic auto_i,
	input wire logic [7:0] spacing_i,
	input wire logic txd_dom_i,
	output logic wd_trig_o,
	output logic txd_o
);
	// ---------------------------------------------------------------
	// trigger pacing
	// ---------------------------------------------------------------
	logic [7:0] cnt_r;
	logic [7:0] due;
	logic live;
	// prompt first trigger; later ones at the spacing the bench sets, which may be wrong on purpose
	assign due = (mode_i == ST_STARTWD) ? 8'h03 : spacing_i;
	assign live = host_rst_n_i && auto_i && (mode_i inside {ST_STARTWD, ST_STANDBY, ST_NORMAL});
	always @(posedge clk_i) begin
		// a host held in reset cannot trigger
		if (!live || wd_trig_o) begin
			cnt_r <= 8'h00;
			wd_trig_o <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			wd_trig_o <= (cnt_r + 8'h01 == due);
		end
	end
	assign txd_o = !txd_dom_i;
endmodule // host_model

//--- tb/mode_wake_watchdog_supervisor_tb.sv
// bench for the supervisor: one task per scenario, host model on the far side
// assumes sup_pkg; long counts shortened through the parameters below
`timescale 1ns/1ps
module mode_wake_watchdog_supervisor_tb
	import sup_pkg::*;
;
	localparam int RES = 50;
	localparam int WDI = 200;
	localparam int DTO = 40;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [1:0] cmd = CMD_NONE;
	logic txd_dom = 1'b0;
	logic bus_rx = 1'b1;
	logic wake = 1'b0;
	logic auto_on = 1'b1;
	logic clk_en = 1'b1;
	logic [7:0] spc = 8'h28;
	logic trig, txd, hrst_n, tx_drv, txd_f, bus_f, rw, lw, wf;
	logic [2:0] mode;
	int n_mismatch = 0;
	int comparisons = 0;
	int n_rw = 0;
	int n_lw = 0;
	int n_wf = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	mode_wake_watchdog_supervisor #(.RES_CYCLES(RES), .WDINIT_CYCLES(WDI), .WIN_PERIOD(80),
		.DOMTO_CYCLES(DTO)) u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en),
		.mode_cmd_i(cmd), .wd_trig_i(trig), .txd_i(txd), .bus_rx_i(bus_rx), .wake_pin_i(wake),
		.host_rst_n_o(hrst_n), .mode_o(mode), .tx_drive_o(tx_drv), .txd_fail_o(txd_f),
		.bus_fail_o(bus_f), .remote_wake_o(rw), .local_wake_o(lw), .wd_fail_o(wf));
	host_model u_host (.clk_i(sys_clk_i), .host_rst_n_i(hrst_n), .mode_i(mode),
		.auto_i(auto_on), .spacing_i(spc), .txd_dom_i(txd_dom), .wd_trig_o(trig), .txd_o(txd));
	// ---------------------------------------------------------------
	// pulse counters and helpers
	// ---------------------------------------------------------------
	// counted mid-cycle, where the one-cycle pulses have settled
	always @(negedge sys_clk_i) begin
		if (rw === 1'b1) n_rw++;
		if (lw === 1'b1) n_lw++;
		if (wf === 1'b1) n_wf++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask
	task automatic chk3(input logic [2:0] got, input logic [2:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s count %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task automatic wait_mode(input logic [2:0] m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++)
			tick(1);
		chk3(mode, m, "mode");
	endtask
	task automatic give_verdict;
		$display("TB: checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_power_up(input logic host_on);
		auto_on = host_on;
		nrst_i = 1'b0;
		tick(4);
		chk1(hrst_n, 1'b0, "host reset during reset");
		nrst_i = 1'b1;
		tick(RES - 4);
		chk3(mode, ST_RESET, "reset delay");
		wait_mode(ST_STARTWD, 8);
	endtask
	task automatic t_start_miss;
		t_power_up(1'b0);
		// a low clock enable must stop the start-up timer and hold the mode and the host reset
		clk_en = 1'b0;
		tick(WDI + 10);
		chk3(mode, ST_STARTWD, "frozen start timer");
		chk1(hrst_n, 1'b1, "frozen host reset");
		clk_en = 1'b1;
		tick(WDI - 4);
		chk3(mode, ST_STARTWD, "init time");
		wait_mode(ST_RESET, 8);
		chk1(hrst_n, 1'b0, "host reset again");
		auto_on = 1'b1;
		wait_mode(ST_STANDBY, RES + 16);
	endtask
	task automatic t_normal;
		int f;
		f = n_wf;
		tick(300);
		chkn(n_wf - f, 0, "wd fail in window");
		cmd = CMD_NORMAL;
		wait_mode(ST_NORMAL, 3);
		cmd = CMD_STANDBY;
		wait_mode(ST_STANDBY, 3);
		cmd = CMD_NORMAL;
		wait_mode(ST_NORMAL, 3);
		cmd = CMD_NONE;
	endtask
	task automatic t_window(input logic [7:0] s);
		int f;
		f = n_wf;
		for (int i = 0; i < 64 && trig !== 1'b1; i++)
			tick(1);
		spc = s;
		wait_mode(ST_RESET, 64);
		tick(1);
		chkn(n_wf - f, 1, "wd fail pulse");
		spc = 8'h28;
		wait_mode(ST_STANDBY, RES + 16);
	endtask
	task automatic t_dom(input logic on_bus);
		txd_dom = !on_bus;
		bus_rx = !on_bus;
		tick(DTO - 2);
		chk1(on_bus ? bus_f : txd_f, 1'b0, "fail too early");
		chk1(tx_drv, !on_bus, "tx drive");
		tick(6);
		chk1(on_bus ? bus_f : txd_f, 1'b1, "fail flag");
		chk1(tx_drv, 1'b0, "tx recessive");
		txd_dom = 1'b0;
		bus_rx = 1'b1;
		tick(3);
		chk1(on_bus ? bus_f : txd_f, 1'b0, "fail cleared");
	endtask
	task automatic t_local(input int hold, input int exp);
		int f;
		f = n_lw;
		wake = 1'b1;
		tick(hold);
		wake = 1'b0;
		tick(790 - hold);
		chkn(n_lw - f, 0, "local wake early");
		tick(60);
		chkn(n_lw - f, exp, "local wake");
		tick(900);
	endtask
	task automatic t_remote(input int d1, input int exp);
		int f;
		f = n_rw;
		bus_rx = 1'b0;
		tick(d1);
		bus_rx = 1'b1;
		tick(130);
		bus_rx = 1'b0;
		tick(130);
		bus_rx = 1'b1;
		tick(580);
		chkn(n_rw - f, 0, "remote wake early");
		tick(60);
		chkn(n_rw - f, exp, "remote wake");
		tick(800);
	endtask
	task automatic t_sleep;
		cmd = CMD_SLEEP;
		wait_mode(ST_SLEEP, 3);
		cmd = CMD_NONE;
		wake = 1'b1;
		wait_mode(ST_STANDBY, 900 + RES + 16);
		wake = 1'b0;
	endtask
	initial begin
		t_power_up(1'b1);
		wait_mode(ST_STANDBY, 8);
		t_normal;
		t_dom(1'b0);
		t_dom(1'b1);
		t_window(8'h64);
		t_window(8'h0A);
		t_local(5, 0);
		t_local(60, 1);
		t_remote(125, 1);
		t_remote(100, 0);
		t_sleep;
		t_start_miss;
		give_verdict;
	end
	// hang guard, about twice the expected run
	initial begin
		#(40 * 20000);
		n_mismatch++;
		give_verdict;
	end
endmodule // mode_wake_watchdog_supervisor_tb
